// >>> cgms_pkg.sv
`default_nettype none
// ---------------------------------------------------------------
// shared constants of the clock generator mode control
// ---------------------------------------------------------------
package cgms_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // time a selection change takes to show in its status bit
  localparam int SWITCH_NS     = 200;
  localparam int SWITCH_CYCLES = (SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] ADDR_OSC          = 8'h04;
  localparam logic [7:0] ADDR_PLL_SELECT   = 8'h08;
  localparam logic [7:0] ADDR_FLL_RANGE    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS       = 8'h10;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CLOCK_SELECT_RST = 8'h04;
  localparam logic [7:0] OSC_RST          = 8'h40;
  localparam logic [7:0] PLL_SELECT_RST   = 8'h01;
  localparam logic [7:0] FLL_RANGE_RST    = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CS_SRC_HI   = 7;
  localparam int CS_SRC_LO   = 6;
  localparam int CS_REFD_HI  = 5;
  localparam int CS_REFD_LO  = 3;
  localparam int CS_IREF     = 2;
  localparam int OSC_BUSD_HI = 7;
  localparam int OSC_BUSD_LO = 6;
  localparam int OSC_RANGE   = 5;
  localparam int OSC_GAIN    = 4;
  localparam int OSC_LPWR    = 3;
  localparam int OSC_XTAL    = 2;
  localparam int OSC_EREN    = 1;
  localparam int PLL_SEL     = 6;
  localparam int PLL_EXT     = 4;
  localparam int PLL_MULT_HI = 3;
  localparam int PLL_MULT_LO = 0;
  localparam int FR_BOOST    = 5;
  localparam int FR_RNG_HI   = 1;
  localparam int FR_RNG_LO   = 0;
  localparam int ST_LOCK     = 6;
  localparam int ST_PLL      = 5;
  localparam int ST_IREF     = 4;
  localparam int ST_SRC_HI   = 3;
  localparam int ST_SRC_LO   = 2;
  localparam int ST_OSC      = 1;

  // ---------------------------------------------------------------
  // codes and factors
  // ---------------------------------------------------------------
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_INT  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;
  localparam logic [1:0] SRC_PLL  = 2'h3;

  localparam logic [1:0] RNG_LOW = 2'h0;
  localparam logic [1:0] RNG_MID = 2'h1;

  localparam logic [10:0] FLL_F_LOW       = 11'h200;
  localparam logic [10:0] FLL_F_MID       = 11'h400;
  localparam logic [10:0] FLL_F_HIGH      = 11'h600;
  localparam logic [10:0] FLL_F_BOOST_LOW = 11'h260;
  localparam logic [10:0] FLL_F_BOOST_MID = 11'h4c0;
  localparam logic [10:0] FLL_F_BOOST_HI  = 11'h720;

  // extra reference divide of 32 in fll external operation
  localparam logic [3:0] EXT_DIV_SHIFT = 4'h5;
  // pll multiplier is the code times four
  localparam logic [1:0] PLL_MULT_PAD  = 2'h0;

  typedef enum logic [7:0] {
    FLL_INTERNAL_MODE        = 8'h01,
    FLL_EXTERNAL_MODE        = 8'h02,
    FLL_BYPASS_EXTERNAL_MODE = 8'h04,
    FLL_BYPASS_INTERNAL_MODE = 8'h08,
    PLL_EXTERNAL_MODE        = 8'h10,
    PLL_BYPASS_EXTERNAL_MODE = 8'h20,
    LOWPOWER_INTERNAL_MODE   = 8'h40,
    LOWPOWER_EXTERNAL_MODE   = 8'h80
  } cgms_mode_t;

endpackage
`default_nettype wire

// >>> cgms_follow_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cgms_follow_if #(
  parameter int W = 1
);
  logic [W-1:0] req;
  logic [W-1:0] stat;
  logic         busy;

  modport src (output req, input stat, input busy);
  modport fol (input req, output stat, output busy);
endinterface
`default_nettype wire

// >>> cgms_follower.sv
`timescale 1ns/1ps
`default_nettype none
// status copy of a selection field of W bits; it takes the requested value once the
// request has differed from it for SETTLE cycles, even if it changed meanwhile
module cgms_follower #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0,
  parameter int           SETTLE    = cgms_pkg::SWITCH_CYCLES
) (
  input  wire logic      clk_sys,
  input  wire logic      srst,
  cgms_follow_if.fol     f
);
  localparam int CW = $clog2(SETTLE + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE - 1);

  typedef struct packed {
    logic [W-1:0]  stat;
    logic [CW-1:0] cnt;
  } cgms_fol_state_t;

  cgms_fol_state_t s;
  cgms_fol_state_t next_s;

  always_comb
  begin
    next_s = s;
    // a request that changes mid-way restarts nothing: the target simply moves
    if (f.req != s.stat)
    begin
      if (s.cnt == LAST)
      begin
        next_s.stat = f.req;
        next_s.cnt  = '0;
      end
      else
      begin
        next_s.cnt = s.cnt + CW'(1);
      end
    end
    else
    begin
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      s <= '{stat: RESET_VAL, cnt: '0};
    else
      s <= next_s;
  end

  assign f.stat = s.stat;
  assign f.busy = (f.req != s.stat);

endmodule // cgms_follower
`default_nettype wire

// >>> cgms_top.sv
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - boost clear: range codes 0,1,2 give fll factors 512, 1024, 1536.
// - boost set: range codes 0,1,2 give fll factors 608, 1216, 1824.
// - range writes take effect except while low-power bypass or pll select is set.
// - selection changes show in status bits; software waits for them.
// - bus clock is the generator output divided by two.
// - fll internal engaged: internal reference times fll factor over bus divider.
// - fll external engaged: external over ref divider, times factor, over bus divider.
// - bypassed modes output the selected reference over the bus divider.
// - pll external engaged: external over ref divider, times multiplier, over bus divider.
// - oscillator control holds bus divider, range, gain, crystal select, ref output.
// - clock select holds source, ref divider, internal ref select; 2 external, 0 loop.
// - source status reads 2 for external, 3 for pll output.
// - internal ref status reads 0 once external reference is active.
// - oscillator ready rises once the selected crystal is initialised.
// - pll select control holds select, divider extension, multiplier; code 8 is x32.
// - ref divider code 3 divides 256 in fll external with extension, 8 for pll.
// - divider extension is ignored in pll modes but keeps its value.
// - in low-power external the pll is off; pll settings only prepare.
// - low-power bypass bit enters low-power mode only from a bypassed mode; clearing returns to bypass on the same reference.
// - lock status rises once the selected loop has locked.
// - pll status reads 1 when the pll feeds the loop clock, 0 for fll.
// - reset starts in fll internal engaged mode with bus divide-by-2.
// - source code 1 selects internal reference and source status reads 1.
module cgms_top #(
  parameter int ADDR_W        = 8,
  parameter int SETTLE_CYCLES = cgms_pkg::SWITCH_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              osc_stable,
  input  wire logic              fll_lock_in,
  input  wire logic              pll_lock_in,
  input  wire logic [31:0]       f_int_hz,
  input  wire logic [31:0]       f_ext_hz,
  output logic                   osc_enable,
  output logic                   high_gain_osc,
  output logic                   osc_range,
  output logic                   ext_ref_out_enable,
  output logic                   fll_enable,
  output logic                   pll_enable,
  output logic      [10:0]       fll_factor,
  output logic      [3:0]        ref_div_shift,
  output logic      [5:0]        pll_multiplier,
  output logic      [7:0]        clock_mode,
  output logic      [31:0]       gen_output_clock_hz,
  output logic      [31:0]       bus_clock_hz
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]         clock_select_ctrl;
    logic [7:0]         oscillator_ctrl;
    logic [7:0]         pll_select_ctrl;
    logic [7:0]         fll_range_ctrl;
    logic [1:0]         osc_sync;
    logic [1:0]         fll_sync;
    logic [1:0]         pll_sync;
    logic [31:0]        prdata;
    logic               pslverr;
    cgms_pkg::cgms_mode_t mode;
    logic [10:0]        fll_factor;
    logic [3:0]         ref_shift;
    logic [5:0]         pll_mult;
    logic [31:0]        gen_hz;
    logic [31:0]        bus_hz;
    logic               osc_ready;
    logic               lock;
    logic               osc_en;
    logic               fll_en;
    logic               pll_en;
  } cgms_state_t;

  localparam cgms_state_t STATE_RST = '{
    clock_select_ctrl: cgms_pkg::CLOCK_SELECT_RST,
    oscillator_ctrl:   cgms_pkg::OSC_RST,
    pll_select_ctrl:   cgms_pkg::PLL_SELECT_RST,
    fll_range_ctrl:    cgms_pkg::FLL_RANGE_RST,
    mode:              cgms_pkg::FLL_INTERNAL_MODE,
    fll_factor:        cgms_pkg::FLL_F_LOW,
    fll_en:            1'b1,
    default:           '0
  };

  cgms_state_t s;
  cgms_state_t next_s;

  // ---------------------------------------------------------------
  // register fields
  // ---------------------------------------------------------------
  logic [1:0] src_sel;
  logic [2:0] ref_divider;
  logic       internal_ref_select;
  logic [1:0] bus_divider;
  logic       low_power_bypass;
  logic       crystal_select;
  logic       ext_ref_out_en;
  logic       pll_select;
  logic       ref_div_extend;
  logic [3:0] pll_mult_code;
  logic       low_ref_boost;
  logic [1:0] fll_range_sel;

  assign src_sel             = s.clock_select_ctrl[cgms_pkg::CS_SRC_HI:cgms_pkg::CS_SRC_LO];
  assign ref_divider         = s.clock_select_ctrl[cgms_pkg::CS_REFD_HI:cgms_pkg::CS_REFD_LO];
  assign internal_ref_select = s.clock_select_ctrl[cgms_pkg::CS_IREF];
  assign bus_divider         = s.oscillator_ctrl[cgms_pkg::OSC_BUSD_HI:cgms_pkg::OSC_BUSD_LO];
  assign low_power_bypass    = s.oscillator_ctrl[cgms_pkg::OSC_LPWR];
  assign crystal_select      = s.oscillator_ctrl[cgms_pkg::OSC_XTAL];
  assign ext_ref_out_en      = s.oscillator_ctrl[cgms_pkg::OSC_EREN];
  assign pll_select          = s.pll_select_ctrl[cgms_pkg::PLL_SEL];
  assign ref_div_extend      = s.pll_select_ctrl[cgms_pkg::PLL_EXT];
  assign pll_mult_code       = s.pll_select_ctrl[cgms_pkg::PLL_MULT_HI:cgms_pkg::PLL_MULT_LO];
  assign low_ref_boost       = s.fll_range_ctrl[cgms_pkg::FR_BOOST];
  assign fll_range_sel       = s.fll_range_ctrl[cgms_pkg::FR_RNG_HI:cgms_pkg::FR_RNG_LO];

  // ---------------------------------------------------------------
  // status followers
  // ---------------------------------------------------------------
  cgms_follow_if #(.W(1)) pll_f ();
  cgms_follow_if #(.W(1)) iref_f ();
  cgms_follow_if #(.W(2)) src_f ();

  logic       pll_st;
  logic       iref_st;
  logic [1:0] src_st;

  assign pll_st  = pll_f.stat[0];
  assign iref_st = iref_f.stat[0];
  assign src_st  = src_f.stat;

  // in low-power bypass the pll select only prepares the next mode
  assign pll_f.req  = low_power_bypass ? pll_f.stat : pll_select;
  assign iref_f.req = internal_ref_select;

  always_comb
  begin
    case (src_sel)
      cgms_pkg::SRC_INT: src_f.req = cgms_pkg::SRC_INT;
      cgms_pkg::SRC_EXT: src_f.req = cgms_pkg::SRC_EXT;
      // the loop output reports which loop drives it; code 3 acts as 0
      default:           src_f.req = pll_st ? cgms_pkg::SRC_PLL : cgms_pkg::SRC_LOOP;
    endcase
  end

  cgms_follower #(.W(1), .RESET_VAL(1'b0), .SETTLE(SETTLE_CYCLES)) u_pll_fol (
    .clk_sys (clk_sys),
    .srst    (srst),
    .f       (pll_f)
  );

  cgms_follower #(.W(1), .RESET_VAL(1'b1), .SETTLE(SETTLE_CYCLES)) u_iref_fol (
    .clk_sys (clk_sys),
    .srst    (srst),
    .f       (iref_f)
  );

  cgms_follower #(.W(2), .RESET_VAL(cgms_pkg::SRC_LOOP), .SETTLE(SETTLE_CYCLES)) u_src_fol (
    .clk_sys (clk_sys),
    .srst    (srst),
    .f       (src_f)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [7:0]  status_byte;
  logic        wr_en;
  logic [7:0]  wbyte;
  logic [3:0]  ref_shift_n;
  logic [10:0] factor_n;
  logic [5:0]  mult_n;
  logic [31:0] f_div;
  logic [42:0] raw_hz;
  logic [42:0] gen_n;
  logic        fll_en_n;
  logic        pll_en_n;

  always_comb
  begin
    next_s = s;

    // pin inputs pass two flip-flops before use
    next_s.osc_sync = {s.osc_sync[0], osc_stable};
    next_s.fll_sync = {s.fll_sync[0], fll_lock_in};
    next_s.pll_sync = {s.pll_sync[0], pll_lock_in};

    status_byte = '0;
    status_byte[cgms_pkg::ST_LOCK] = s.lock;
    status_byte[cgms_pkg::ST_PLL]  = pll_st;
    status_byte[cgms_pkg::ST_IREF] = iref_st;
    status_byte[cgms_pkg::ST_SRC_HI:cgms_pkg::ST_SRC_LO] = src_st;
    status_byte[cgms_pkg::ST_OSC]  = s.osc_ready;

    // read data and error are caught in the setup cycle
    if (psel && !penable)
    begin
      next_s.pslverr = 1'b0;
      case (paddr[7:0])
        cgms_pkg::ADDR_CLOCK_SELECT: next_s.prdata = {24'h000000, s.clock_select_ctrl};
        cgms_pkg::ADDR_OSC:          next_s.prdata = {24'h000000, s.oscillator_ctrl};
        cgms_pkg::ADDR_PLL_SELECT:   next_s.prdata = {24'h000000, s.pll_select_ctrl};
        cgms_pkg::ADDR_FLL_RANGE:    next_s.prdata = {24'h000000, s.fll_range_ctrl};
        cgms_pkg::ADDR_STATUS:       next_s.prdata = {24'h000000, status_byte};
        default:
        begin
          next_s.prdata  = '0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end

    wr_en = psel && penable && pwrite;
    wbyte = pwdata[7:0];
    if (wr_en)
    begin
      case (paddr[7:0])
        cgms_pkg::ADDR_CLOCK_SELECT: next_s.clock_select_ctrl = wbyte;
        cgms_pkg::ADDR_OSC:          next_s.oscillator_ctrl   = wbyte;
        // bit 7 and bit 5 of this register read back as written
        cgms_pkg::ADDR_PLL_SELECT:   next_s.pll_select_ctrl   = wbyte;
        cgms_pkg::ADDR_FLL_RANGE:
        begin
          next_s.fll_range_ctrl[cgms_pkg::FR_BOOST] = wbyte[cgms_pkg::FR_BOOST];
          if (!(low_power_bypass || pll_select))
          begin
            next_s.fll_range_ctrl[cgms_pkg::FR_RNG_HI:cgms_pkg::FR_RNG_LO] =
              wbyte[cgms_pkg::FR_RNG_HI:cgms_pkg::FR_RNG_LO];
          end
        end
        default:
        begin
          next_s.pslverr = s.pslverr;
        end
      endcase
    end

    // loops: low-power bypass stops both, pll select picks one
    fll_en_n = !low_power_bypass && !pll_st;
    pll_en_n = !low_power_bypass && pll_st;
    next_s.fll_en = fll_en_n;
    next_s.pll_en = pll_en_n;
    next_s.osc_en = ext_ref_out_en || !internal_ref_select;
    next_s.osc_ready = crystal_select && s.osc_en && s.osc_sync[1];
    next_s.lock = pll_st ? (pll_en_n && s.pll_sync[1]) : (fll_en_n && s.fll_sync[1]);

    // active mode from what the status bits show and from the low-power bypass bit
    case (src_st)
      cgms_pkg::SRC_LOOP:
        next_s.mode = iref_st ? cgms_pkg::FLL_INTERNAL_MODE : cgms_pkg::FLL_EXTERNAL_MODE;
      cgms_pkg::SRC_INT:
        next_s.mode = low_power_bypass ? cgms_pkg::LOWPOWER_INTERNAL_MODE
                                       : cgms_pkg::FLL_BYPASS_INTERNAL_MODE;
      cgms_pkg::SRC_EXT:
        if (low_power_bypass)
          next_s.mode = cgms_pkg::LOWPOWER_EXTERNAL_MODE;
        else
          next_s.mode = pll_st ? cgms_pkg::PLL_BYPASS_EXTERNAL_MODE
                               : cgms_pkg::FLL_BYPASS_EXTERNAL_MODE;
      default:
        next_s.mode = cgms_pkg::PLL_EXTERNAL_MODE;
    endcase

    // reference divider; the extension only counts for the fll on the external reference
    if (!pll_st && !iref_st && ref_div_extend)
      ref_shift_n = {1'b0, ref_divider} + cgms_pkg::EXT_DIV_SHIFT;
    else
      ref_shift_n = {1'b0, ref_divider};

    case (fll_range_sel)
      cgms_pkg::RNG_LOW:
        factor_n = low_ref_boost ? cgms_pkg::FLL_F_BOOST_LOW : cgms_pkg::FLL_F_LOW;
      cgms_pkg::RNG_MID:
        factor_n = low_ref_boost ? cgms_pkg::FLL_F_BOOST_MID : cgms_pkg::FLL_F_MID;
      // code 3 behaves as code 2
      default:
        factor_n = low_ref_boost ? cgms_pkg::FLL_F_BOOST_HI : cgms_pkg::FLL_F_HIGH;
    endcase

    mult_n = {pll_mult_code, cgms_pkg::PLL_MULT_PAD};
    f_div  = f_ext_hz >> ref_shift_n;

    case (next_s.mode)
      cgms_pkg::FLL_INTERNAL_MODE: raw_hz = 43'(f_int_hz) * 43'(factor_n);
      cgms_pkg::FLL_EXTERNAL_MODE: raw_hz = 43'(f_div) * 43'(factor_n);
      cgms_pkg::PLL_EXTERNAL_MODE: raw_hz = 43'(f_div) * 43'(mult_n);
      cgms_pkg::FLL_BYPASS_INTERNAL_MODE,
      cgms_pkg::LOWPOWER_INTERNAL_MODE: raw_hz = 43'(f_int_hz);
      default: raw_hz = 43'(f_ext_hz);
    endcase

    // results above 32 bits wrap; real settings stay far below
    gen_n = raw_hz >> bus_divider;
    next_s.gen_hz     = gen_n[31:0];
    next_s.bus_hz     = gen_n[32:1];
    next_s.fll_factor = factor_n;
    next_s.ref_shift  = ref_shift_n;
    next_s.pll_mult   = mult_n;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      s <= STATE_RST;
    else
      s <= next_s;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pready              = psel && penable;
  assign pslverr             = psel && penable && s.pslverr;
  assign prdata              = s.prdata;
  assign osc_enable          = s.osc_en;
  assign high_gain_osc       = s.oscillator_ctrl[cgms_pkg::OSC_GAIN];
  assign osc_range           = s.oscillator_ctrl[cgms_pkg::OSC_RANGE];
  assign ext_ref_out_enable  = ext_ref_out_en;
  assign fll_enable          = s.fll_en;
  assign pll_enable          = s.pll_en;
  assign fll_factor          = s.fll_factor;
  assign ref_div_shift       = s.ref_shift;
  assign pll_multiplier      = s.pll_mult;
  assign clock_mode          = s.mode;
  assign gen_output_clock_hz = s.gen_hz;
  assign bus_clock_hz        = s.bus_hz;

endmodule // cgms_top
`default_nettype wire

// >>> cgms_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// crystal model: it settles only after START enabled cycles, so the
// ready poll must really wait
module cgms_osc_model #(
  parameter int          START = 12,
  parameter logic [31:0] FREQ  = 32'h007a1200
) (
  input  wire logic        clk_sys,
  input  wire logic        osc_enable,
  output logic             osc_stable,
  output logic      [31:0] f_ext_hz
);
  int cnt = 0;
  // 8 MHz keeps pll modes legal and divides to valid loop references
  assign f_ext_hz = FREQ;
  always @(posedge clk_sys)
  begin
    if (!osc_enable)
    begin
      cnt        <= 0;
      osc_stable <= 1'b0;
    end
    else if (cnt < START)
      cnt <= cnt + 1;
    else
      osc_stable <= 1'b1;
  end
endmodule // cgms_osc_model
`default_nettype wire

// >>> cgms_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cgms_top_monitor (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_ref_out_enable,
  input wire logic        osc_enable,
  input wire logic        fll_enable,
  input wire logic        pll_enable,
  input wire logic [10:0] fll_factor,
  input wire logic [7:0]  clock_mode,
  input wire logic [31:0] gen_output_clock_hz,
  input wire logic [31:0] bus_clock_hz
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_bus_half: assert property (bus_clock_hz[30:0] == gen_output_clock_hz[31:1])
    else $error("bus clock not half of output clock");
  a_fll_factor: assert property (fll_factor inside {11'h200, 11'h400, 11'h600,
    11'h260, 11'h4c0, 11'h720}) else $error("illegal fll factor");
  a_reset_mode: assert property ($fell(srst) |-> clock_mode == 8'h01 && fll_enable
    && fll_factor == 11'h200) else $error("wrong state after reset");
  a_lowpwr_off: assert property (clock_mode == 8'h80 |-> !pll_enable && !fll_enable)
    else $error("loop running in low power external");
  a_pll_mode: assert property (pll_enable |-> clock_mode inside {8'h10, 8'h20})
    else $error("pll on outside pll modes");
  a_fll_mode: assert property (fll_enable |-> clock_mode inside {8'h01, 8'h02, 8'h04, 8'h08})
    else $error("fll on outside fll modes");
  a_osc_follow: assert property (ext_ref_out_enable |=> osc_enable)
    else $error("oscillator off with reference output on");
  a_access_data: assert property (psel && penable |-> pready && prdata[31:8] == 24'h0)
    else $error("bad access phase answer");
  a_err_map: assert property (psel && penable |-> pslverr ==
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10})) else $error("wrong error response");
endmodule // cgms_top_monitor
bind cgms_top cgms_top_monitor u_mon (.clk_sys(clk_sys), .srst(srst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_ref_out_enable(ext_ref_out_enable), .osc_enable(osc_enable), .fll_enable(fll_enable),
  .pll_enable(pll_enable), .fll_factor(fll_factor), .clock_mode(clock_mode),
  .gen_output_clock_hz(gen_output_clock_hz), .bus_clock_hz(bus_clock_hz));
`default_nettype wire

// >>> cgms_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cgms_top_tb;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, f_ext_hz, gen_hz, bus_hz, x;
  logic        pready, pslverr, osc_stable, osc_en, ero, fll_en, pll_en;
  logic        fll_lock_in = 1'b0, pll_lock_in = 1'b0;
  logic [10:0] fll_factor;
  logic [5:0]  pll_mult;
  logic        gain_out, range_out;
  logic [3:0]  rds;
  logic [7:0]  clock_mode;
  logic [7:0]  fr[6] = '{8'h00, 8'h01, 8'h02, 8'h20, 8'h21, 8'h22};
  logic [10:0] fv[6] = '{11'h200, 11'h400, 11'h600, 11'h260, 11'h4c0, 11'h720};
  int          errors = 0, samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  // loops lock one cycle after they are enabled
  always @(posedge clk_sys)
  begin
    fll_lock_in <= fll_en;
    pll_lock_in <= pll_en;
  end
  cgms_osc_model u_osc (.clk_sys(clk_sys), .osc_enable(osc_en), .osc_stable(osc_stable),
    .f_ext_hz(f_ext_hz));
  cgms_top #(.SETTLE_CYCLES(2)) DUT (.clk_sys(clk_sys), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_stable(osc_stable), .fll_lock_in(fll_lock_in),
    .pll_lock_in(pll_lock_in), .f_int_hz(32'h00008000), .f_ext_hz(f_ext_hz),
    .osc_enable(osc_en), .high_gain_osc(gain_out), .osc_range(range_out),
    .ext_ref_out_enable(ero), .fll_enable(fll_en), .pll_enable(pll_en),
    .fll_factor(fll_factor), .ref_div_shift(rds),
    .pll_multiplier(pll_mult), .clock_mode(clock_mode), .gen_output_clock_hz(gen_hz),
    .bus_clock_hz(bus_hz));
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic finish_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    for (n = 0; pready !== 1'b1 && n < 40; n++) @(posedge clk_sys);
    chk(n < 40, 1'b1);
    if (n == 40) finish_test();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, {24'h0, v});
    chk(e, ee);
  endtask
  // software waits for each status change before the next step
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    logic [31:0] r;
    logic        e;
    int          k;
    for (k = 0; k < 100; k++)
    begin
      apb(1'b0, 8'h10, 8'h00, r, e);
      if ((r[7:0] & m) === v) break;
    end
    chk(r[7:0] & m, v);
    if (k == 100) finish_test();
    repeat (4) @(posedge clk_sys);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    rd(8'h00, 8'h04, 1'b0);
    rd(8'h04, 8'h40, 1'b0);
    rd(8'h08, 8'h01, 1'b0);
    rd(8'h0c, 8'h00, 1'b0);
    rd(8'h14, 8'h00, 1'b1);
    poll(8'h3e, 8'h10);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h0c, fr[i]);
      x = (32'h00008000 * fv[i]) >> 1;
      chk(fll_factor, fv[i]);
      chk(gen_hz, x);
      chk(bus_hz, x >> 1);
    end
    wr(8'h0c, 8'h00);
    wr(8'h04, 8'h48);
    wr(8'h0c, 8'h01);
    rd(8'h0c, 8'h00, 1'b0);
    $display("test fll factors done");
    wr(8'h04, 8'h36);
    poll(8'h02, 8'h02);
    chk({gain_out, range_out, ero}, 3'h7);
    wr(8'h08, 8'h11);
    wr(8'h00, 8'h98);
    poll(8'h1c, 8'h08);
    chk(clock_mode, 8'h04);
    chk(gen_hz, 32'h007a1200);
    wr(8'h00, 8'h18);
    poll(8'h1c, 8'h00);
    chk(gen_hz, 32'h00f42400);
    chk(rds, 4'h8);
    wr(8'h00, 8'h98);
    poll(8'h0c, 8'h08);
    wr(8'h04, 8'h3e);
    chk(clock_mode, 8'h80);
    wr(8'h08, 8'h58);
    chk(pll_en, 1'b0);
    rd(8'h08, 8'h58, 1'b0);
    wr(8'h0c, 8'h02);
    rd(8'h0c, 8'h00, 1'b0);
    wr(8'h04, 8'h36);
    poll(8'h60, 8'h60);
    chk(clock_mode, 8'h20);
    wr(8'h00, 8'h18);
    poll(8'h0c, 8'h0c);
    chk(gen_hz, 32'h01e84800);
    chk(bus_hz, 32'h00f42400);
    chk(rds, 4'h3);
    chk(pll_mult, 6'h20);
    $display("test pll path done");
    wr(8'h00, 8'h98);
    poll(8'h0c, 8'h08);
    wr(8'h08, 8'h18);
    poll(8'h20, 8'h00);
    wr(8'h00, 8'h5c);
    poll(8'h1c, 8'h14);
    chk(gen_hz, 32'h00008000);
    $display("test internal source done");
    finish_test();
  end
endmodule // cgms_top_tb
`default_nettype wire
